// ### design/core_timer_pkg.sv
// Constants, field layout and register map of the core up/down timer
package core_timer_pkg;

    localparam int            ADDR_W       = 20;
    localparam int            CNT_W        = 16;
    localparam int            PRESC_W      = 10;

    // Register indexes; byte address is four times the index
    localparam logic [19:0]   CTRL_IDX     = 20'hff42;
    localparam logic [19:0]   CNT_IDX      = 20'hff40;
    localparam logic [19:0]   STAT_IDX     = 20'hff44;
    localparam logic [19:0]   CTRL_ADDR    = {CTRL_IDX[17:0], 2'b00};
    localparam logic [19:0]   CNT_ADDR     = {CNT_IDX[17:0], 2'b00};
    localparam logic [19:0]   STAT_ADDR    = {STAT_IDX[17:0], 2'b00};

    // Control and status field positions
    localparam int            ISEL_LSB     = 0;
    localparam int            MODE_LSB     = 3;
    localparam int            RUN_BIT      = 6;
    localparam int            SWDIR_BIT    = 7;
    localparam int            EXTDIR_BIT   = 8;
    localparam int            OEN_BIT      = 9;
    localparam int            TLATCH_BIT   = 10;
    localparam int            FLAG_BIT     = 0;

    localparam logic [15:0]   CTRL_RST     = 16'h0000;
    localparam logic [15:0]   CNT_RST      = 16'h0000;

    // Timer step is 8 << select cycles
    localparam int            PRESC_BASE   = 3;

    localparam logic [2:0]    MODE_TIMER   = 3'h0;
    localparam logic [2:0]    MODE_COUNTER = 3'h1;
    localparam logic [2:0]    MODE_GATE_LO = 3'h2;
    localparam logic [2:0]    MODE_GATE_HI = 3'h3;
    localparam logic [2:0]    MODE_ENCODER = 3'h6;

    localparam logic [2:0]    EDGE_NONE    = 3'h0;
    localparam logic [2:0]    EDGE_RISE    = 3'h1;
    localparam logic [2:0]    EDGE_FALL    = 3'h2;
    localparam logic [2:0]    EDGE_ANY     = 3'h3;

endpackage

// ### design/pin_sync_edge.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module pin_sync_edge
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin_async,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_async;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
    assign fall  = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ### design/core_timer.sv
// Core 16-bit up/down timer with toggle latch, APB register slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module core_timer
    import core_timer_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              gate_count_pin,
    input  wire logic              direction_pin,
    input  wire logic              port_data_latch,
    input  wire logic              output_pin_port_dir_bit,
    output logic                   toggle_output_pin,
    output logic                   toggle_output_pin_oe,
    output logic                   aux_toggle_state,
    output logic                   aux_wrap_event,
    output logic                   wrap_flag
);
    logic [2:0]         isel_ff;
    logic [2:0]         mode_ff;
    logic               run_ff;
    logic               swdir_ff;
    logic               extdir_ff;
    logic               oen_ff;
    logic               tlatch_ff;
    logic [CNT_W-1:0]   count_ff;
    logic               flag_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic [31:0]        prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;
    logic               pin_o_ff;
    logic               pin_oe_ff;
    logic               aux_tog_ff;
    logic               aux_evt_ff;

    logic [2:0]         nxt_isel;
    logic [2:0]         nxt_mode;
    logic               nxt_run;
    logic               nxt_swdir;
    logic               nxt_extdir;
    logic               nxt_oen;
    logic               nxt_tlatch;
    logic [CNT_W-1:0]   nxt_count;
    logic               nxt_flag;
    logic [PRESC_W-1:0] nxt_presc;
    logic [31:0]        nxt_prdata;
    logic               nxt_pready;
    logic               nxt_pslverr;
    logic               nxt_pin_o;
    logic               nxt_pin_oe;
    logic               nxt_aux_tog;
    logic               nxt_aux_evt;

    logic a_lvl;
    logic a_rise;
    logic a_fall;
    logic b_lvl;
    logic b_rise;
    logic b_fall;

    logic access;
    logic wr_done;
    logic ctrl_wr;
    logic cnt_wr;
    logic stat_wr;
    logic tick;
    logic gate_act;
    logic step;
    logic down;
    logic wrap;

    // Both pins cross in from outside the clock domain
    pin_sync_edge u_sync_a
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (gate_count_pin),
        .level     (a_lvl),
        .rise      (a_rise),
        .fall      (a_fall)
    );

    pin_sync_edge u_sync_b
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (direction_pin),
        .level     (b_lvl),
        .rise      (b_rise),
        .fall      (b_fall)
    );

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [19:0]       r);
        addr_hit = (a == r);
    endfunction

    // Edge picker used by counter mode only; encoder mode decodes its own edges
    function automatic logic edge_pick(input logic [2:0] sel,
                                       input logic       e_one,
                                       input logic       e_two);
        case (sel)
            EDGE_RISE: edge_pick = e_one;
            EDGE_FALL: edge_pick = e_two;
            EDGE_ANY:  edge_pick = e_one | e_two;
            default:   edge_pick = 1'b0;
        endcase
    endfunction

    // One wait state: answer comes in the second access cycle
    assign access  = psel & penable;
    assign wr_done = access & pready_ff & pwrite;
    assign ctrl_wr = wr_done & addr_hit(paddr, CTRL_ADDR);
    assign cnt_wr  = wr_done & addr_hit(paddr, CNT_ADDR);
    assign stat_wr = wr_done & addr_hit(paddr, STAT_ADDR);

    // Free-running prescaler; low select bits all ones marks a step
    assign tick = &(presc_ff | ~((10'h001 << (PRESC_BASE + isel_ff))
                                 - 10'h001));

    assign gate_act = (mode_ff == MODE_GATE_LO) ? ~a_lvl : a_lvl;

    always_comb
    begin
        step = 1'b0;
        down = swdir_ff;
        if (extdir_ff)
            down = b_lvl ^ swdir_ff;
        case (mode_ff)
            MODE_TIMER:   step = tick;
            MODE_GATE_LO,
            MODE_GATE_HI: step = tick & gate_act;
            MODE_COUNTER: step = edge_pick(isel_ff, a_rise,
                                           a_fall);
            MODE_ENCODER:
            begin
                // A edge wins when both inputs move together
                if ((isel_ff == EDGE_RISE || isel_ff == EDGE_ANY) &&
                    (a_rise | a_fall))
                begin
                    step = 1'b1;
                    down = a_rise ? b_lvl : ~b_lvl;
                end
                else if ((isel_ff == EDGE_FALL || isel_ff == EDGE_ANY) &&
                         (b_rise | b_fall))
                begin
                    step = 1'b1;
                    down = b_rise ? ~a_lvl : a_lvl;
                end
            end
            default:      step = 1'b0;
        endcase
        step = step & run_ff;
    end

    assign wrap = step & (down ? (count_ff == 16'h0000)
                               : (count_ff == 16'hffff));

    always_comb
    begin
        nxt_presc   = presc_ff + 10'h001;
        nxt_isel    = isel_ff;
        nxt_mode    = mode_ff;
        nxt_run     = run_ff;
        nxt_swdir   = swdir_ff;
        nxt_extdir  = extdir_ff;
        nxt_oen     = oen_ff;
        nxt_tlatch  = tlatch_ff ^ wrap;
        nxt_count   = count_ff;
        nxt_flag    = flag_ff;
        if (step)
            nxt_count = down ? count_ff - 16'h0001
                             : count_ff + 16'h0001;
        // Direction bits take effect on the very next step
        if (ctrl_wr)
        begin
            nxt_isel   = pwdata[ISEL_LSB +: 3];
            nxt_mode   = pwdata[MODE_LSB +: 3];
            nxt_run    = pwdata[RUN_BIT];
            nxt_swdir  = pwdata[SWDIR_BIT];
            nxt_extdir = pwdata[EXTDIR_BIT];
            nxt_oen    = pwdata[OEN_BIT];
            nxt_tlatch = pwdata[TLATCH_BIT];
        end
        if (cnt_wr)
            nxt_count = pwdata[CNT_W-1:0];
        if (stat_wr && pwdata[FLAG_BIT])
            nxt_flag = 1'b0;
        if (wrap)
            nxt_flag = 1'b1;
    end

    always_comb
    begin
        nxt_pready  = access & ~pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0000_0000;
        if (access && !pready_ff)
        begin
            if (addr_hit(paddr, CTRL_ADDR))
                nxt_prdata[TLATCH_BIT:0] = {tlatch_ff, oen_ff, extdir_ff,
                                            swdir_ff, run_ff, mode_ff,
                                            isel_ff};
            else if (addr_hit(paddr, CNT_ADDR))
                nxt_prdata[CNT_W-1:0] = count_ff;
            else if (addr_hit(paddr, STAT_ADDR))
                nxt_prdata[FLAG_BIT] = flag_ff;
            else
                nxt_pslverr = 1'b1;
        end
        // Port latch must be 1 for the toggle state to reach the pin
        nxt_pin_o   = oen_ff ? (tlatch_ff & port_data_latch)
                             : port_data_latch;
        nxt_pin_oe  = output_pin_port_dir_bit;
        nxt_aux_tog = tlatch_ff;
        nxt_aux_evt = wrap;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            isel_ff    <= CTRL_RST[ISEL_LSB +: 3];
            mode_ff    <= CTRL_RST[MODE_LSB +: 3];
            run_ff     <= CTRL_RST[RUN_BIT];
            swdir_ff   <= CTRL_RST[SWDIR_BIT];
            extdir_ff  <= CTRL_RST[EXTDIR_BIT];
            oen_ff     <= CTRL_RST[OEN_BIT];
            tlatch_ff  <= CTRL_RST[TLATCH_BIT];
            count_ff   <= CNT_RST;
            flag_ff    <= 1'b0;
            presc_ff   <= '0;
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            pin_o_ff   <= 1'b0;
            pin_oe_ff  <= 1'b0;
            aux_tog_ff <= 1'b0;
            aux_evt_ff <= 1'b0;
        end
        else
        begin
            isel_ff    <= nxt_isel;
            mode_ff    <= nxt_mode;
            run_ff     <= nxt_run;
            swdir_ff   <= nxt_swdir;
            extdir_ff  <= nxt_extdir;
            oen_ff     <= nxt_oen;
            tlatch_ff  <= nxt_tlatch;
            count_ff   <= nxt_count;
            flag_ff    <= nxt_flag;
            presc_ff   <= nxt_presc;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            pin_o_ff   <= nxt_pin_o;
            pin_oe_ff  <= nxt_pin_oe;
            aux_tog_ff <= nxt_aux_tog;
            aux_evt_ff <= nxt_aux_evt;
        end
    end

    assign prdata               = prdata_ff;
    assign pready               = pready_ff;
    assign pslverr              = pslverr_ff;
    assign toggle_output_pin    = pin_o_ff;
    assign toggle_output_pin_oe = pin_oe_ff;
    assign aux_toggle_state     = aux_tog_ff;
    assign aux_wrap_event       = aux_evt_ff;
    assign wrap_flag            = flag_ff;

    AST_WRITE_WINS:
    assert property (@(posedge pclk) disable iff (!presetn)
        cnt_wr |=> count_ff == $past(pwdata[CNT_W-1:0]))
        else $error("Count write lost to hardware update");

    AST_HOLD_STOPPED:
    assert property (@(posedge pclk) disable iff (!presetn)
        (!run_ff && !cnt_wr) |=> count_ff == $past(count_ff))
        else $error("Count moved while stopped");

    AST_SW_DIRECTION:
    assert property (@(posedge pclk) disable iff (!presetn)
        (step && !extdir_ff && mode_ff == MODE_TIMER && !cnt_wr)
        |=> count_ff == $past(count_ff) + ($past(swdir_ff) ? 16'hffff
                                                            : 16'h0001))
        else $error("Software direction not followed");

    AST_PRESCALE_GAP:
    assert property (@(posedge pclk) disable iff (!presetn)
        (step && mode_ff == MODE_TIMER && isel_ff == 3'h0 && !ctrl_wr)
        |=> !step [*7])
        else $error("Timer stepped faster than eight cycles");

    AST_WRAP_UP:
    assert property (@(posedge pclk) disable iff (!presetn)
        (step && !down && count_ff == 16'hffff && !cnt_wr)
        |=> count_ff == 16'h0000 && aux_evt_ff)
        else $error("Up wrap missing");

    AST_TOGGLE:
    assert property (@(posedge pclk) disable iff (!presetn)
        (wrap && !ctrl_wr) |=> tlatch_ff != $past(tlatch_ff))
        else $error("Toggle latch did not flip on wrap");

    AST_FLAG_STICKY:
    assert property (@(posedge pclk) disable iff (!presetn)
        wrap |=> flag_ff ##1 (flag_ff || $past(stat_wr)))
        else $error("Wrap flag not set or lost");

    AST_PIN_FOLLOWS:
    assert property (@(posedge pclk) disable iff (!presetn)
        (oen_ff && port_data_latch)
        |=> toggle_output_pin == $past(tlatch_ff))
        else $error("Pin does not show toggle latch");

    AST_AUX_STATE:
    assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> aux_toggle_state == $past(tlatch_ff))
        else $error("Auxiliary toggle state stale");
endmodule
`default_nettype wire

// ### test/pin_partner.sv
// Pin-side model driving the gate, count, encoder and direction pins
`timescale 1ns/1ns
`default_nettype none
module pin_partner
(
    input  wire logic pclk,
    input  wire logic want_a,
    input  wire logic want_b,
    output logic      gate_count_pin = 1'b0,
    output logic      direction_pin = 1'b0
);
    // Pins move just after an edge, as a board driver would
    always @(posedge pclk)
    begin
        gate_count_pin <= want_a;
        direction_pin  <= want_b;
    end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the core timer over APB and its pins
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import core_timer_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic              pready, pslverr, rerr, want_a, want_b;
    logic              gate_count_pin, direction_pin, port_data_latch;
    logic              output_pin_port_dir_bit, toggle_output_pin;
    logic              toggle_output_pin_oe, aux_toggle_state;
    logic              aux_wrap_event, wrap_flag, ex, sw, ga, dp;
    logic [2:0]        m;
    logic [15:0]       ev;
    int                err_count, tests_run, wraps, k;
    // {mode, ext dir enable, sw dir, gate pin, dir pin, expected count}
    logic [22:0]       rows [13] = '{
        {3'd0, 4'b0001, 16'h100a}, {3'd0, 4'b0100, 16'h0ff6},
        {3'd0, 4'b1000, 16'h100a}, {3'd0, 4'b1001, 16'h0ff6},
        {3'd0, 4'b1100, 16'h0ff6}, {3'd0, 4'b1101, 16'h100a},
        {3'd3, 4'b0000, 16'h1000}, {3'd3, 4'b0010, 16'h100a},
        {3'd2, 4'b0000, 16'h100a}, {3'd2, 4'b0010, 16'h1000},
        {3'd4, 4'b0000, 16'h1000}, {3'd5, 4'b0000, 16'h1000},
        {3'd7, 4'b0000, 16'h1000}};
    logic [31:0]       edge_exp [5] = '{32'h0, 32'h3, 32'h3, 32'h6, 32'h0};

    core_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .gate_count_pin,
        .direction_pin, .port_data_latch, .output_pin_port_dir_bit,
        .toggle_output_pin, .toggle_output_pin_oe, .aux_toggle_state,
        .aux_wrap_event, .wrap_flag);
    pin_partner u_pins (.pclk, .want_a, .want_b, .gate_count_pin,
        .direction_pin);

    always #2 pclk = ~pclk;

    always @(posedge pclk)
        if (aux_wrap_event === 1'b1)
            wraps <= wraps + 1;

    function automatic logic [31:0] ctl(input logic [2:0] md,
        input logic [2:0] isel, input logic [4:0] b);
        return {21'h0, b, md, isel};
    endfunction

    task automatic give_verdict();
    begin
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    end
    endtask

    // Answer is taken at the rising edge where pready is seen high
    task automatic xfer(input logic w, input logic [19:0] a,
        input logic [31:0] d);
        int n;
    begin
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps the next setup out of this time step
        @(posedge pclk);
        if (n >= 50)
        begin
            err_count++;
            give_verdict();
        end
    end
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [19:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic pins(input logic a, input logic b);
    begin
        want_a <= a;
        want_b <= b;
        repeat (12) @(posedge pclk);
    end
    endtask

    // Runs for exactly d edges; the stop write keeps the toggle latch
    task automatic window(input logic [31:0] c, input logic [15:0] s,
        input int d);
    begin
        wr(CNT_ADDR, {16'h0, s});
        wr(CTRL_ADDR, c | 32'h40);
        repeat (d - 8) @(posedge pclk);
        rd(CTRL_ADDR);
        wr(CTRL_ADDR, rdat & ~32'h40);
        rd(CNT_ADDR);
    end
    endtask

    initial
    begin
        repeat (100000) @(posedge pclk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        pclk = 0;
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {want_a, want_b, port_data_latch, output_pin_port_dir_bit} = '0;
        {err_count, tests_run, wraps} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL_ADDR);
        check(rdat, 32'h0);
        rd(20'h00010);
        check({rerr, rdat[30:0]}, 32'h80000000);
        wr(CNT_ADDR, 32'h1234);
        repeat (100) @(posedge pclk);
        rd(CNT_ADDR);
        check(rdat, 32'h1234);
        for (k = 0; k < 13; k++)
        begin
            {m, ex, sw, ga, dp, ev} = rows[k];
            pins(ga, dp);
            window(ctl(m, 3'd0, {2'b00, ex, sw, 1'b0}), 16'h1000, 80);
            check(rdat, {16'h0, ev});
        end
        pins(0, 0);
        wr(CNT_ADDR, 32'h1000);
        wr(CTRL_ADDR, ctl(0, 0, 5'b00001));
        repeat (76) @(posedge pclk);
        wr(CTRL_ADDR, ctl(0, 0, 5'b00011));
        repeat (76) @(posedge pclk);
        wr(CTRL_ADDR, ctl(0, 0, 5'b00010));
        rd(CNT_ADDR);
        check(rdat, 32'h1000);
        window(ctl(0, 3, 5'b0), 16'hfffc, 640);
        check(rdat, 32'h6);
        rd(CTRL_ADDR);
        check(rdat, ctl(0, 3, 5'b10000));
        rd(STAT_ADDR);
        check(rdat, 32'h1);
        wr(STAT_ADDR, 32'h1);
        rd(STAT_ADDR);
        check({rdat[31:1], wrap_flag}, 32'h0);
        window(ctl(0, 0, 5'b00010), 16'h0005, 800);
        check(rdat, 32'hffa1);
        rd(CTRL_ADDR);
        check(rdat, ctl(0, 0, 5'b10010));
        check({aux_toggle_state, wraps[30:0]}, 32'h80000002);
        // Port latch and direction bit set as software would
        port_data_latch <= 1'b1;
        output_pin_port_dir_bit <= 1'b1;
        wr(CTRL_ADDR, ctl(0, 0, 5'b01000));
        repeat (3) @(posedge pclk);
        check({30'h0, toggle_output_pin, toggle_output_pin_oe},
              32'h1);
        wr(CTRL_ADDR, ctl(0, 0, 5'b11000));
        repeat (3) @(posedge pclk);
        check({30'h0, toggle_output_pin, aux_toggle_state},
              32'h3);
        wr(CTRL_ADDR, ctl(0, 0, 5'b00000));
        repeat (3) @(posedge pclk);
        check({31'h0, toggle_output_pin}, 32'h1);
        for (k = 0; k < 5; k++)
        begin
            wr(CNT_ADDR, 32'h0);
            wr(CTRL_ADDR, ctl(1, k[2:0], 5'b00001));
            repeat (3)
            begin
                pins(1, 0);
                pins(0, 0);
            end
            rd(CNT_ADDR);
            check(rdat, edge_exp[k]);
        end
        wr(CNT_ADDR, 32'h0100);
        wr(CTRL_ADDR, ctl(6, 3, 5'b00101));
        pins(1, 0);
        pins(1, 1);
        pins(0, 1);
        pins(0, 0);
        rd(CNT_ADDR);
        check(rdat, 32'h0104);
        wr(CNT_ADDR, 32'h0100);
        wr(CTRL_ADDR, ctl(6, 1, 5'b00101));
        pins(0, 1);
        pins(1, 1);
        pins(1, 0);
        pins(0, 0);
        rd(CNT_ADDR);
        check(rdat, 32'h00fe);
        // Sweep the write across all prescaler phases to hit a step
        for (k = 0; k < 8; k++)
        begin
            wr(CTRL_ADDR, ctl(0, 0, 5'b00001));
            repeat (k) @(posedge pclk);
            wr(CNT_ADDR, 32'h4321);
            wr(CTRL_ADDR, ctl(0, 0, 5'b00000));
            rd(CNT_ADDR);
            check(rdat === 32'h4322 ? 32'h4321 : rdat, 32'h4321);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
